// ===== rtl/lsm_pkg.sv
`default_nettype none

package lsm_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CFG_SP   = 8'h04;
  localparam logic [7:0] ADDR_LIMITS   = 8'h08;
  localparam logic [7:0] ADDR_MEAS     = 8'h0C;
  localparam logic [7:0] ADDR_PRESET   = 8'h10;
  localparam logic [7:0] ADDR_SHIFT    = 8'h14;
  localparam logic [7:0] ADDR_TEACH    = 8'h18;
  localparam logic [7:0] ADDR_EVENT    = 8'h1C;
  localparam logic [7:0] ADDR_SETPOINT = 8'h20;
  localparam logic [7:0] ADDR_STATUS   = 8'h24;
  localparam logic [7:0] ADDR_DIM_OUT  = 8'h28;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_OVERWRITE = 0;
  localparam int CTRL_PRESET_EN = 1;
  localparam int CTRL_SHIFT_EN  = 2;
  localparam int CTRL_PERMANENT = 3;
  localparam int CTRL_TEACH_EN  = 4;
  localparam int CTRL_POL_LSB   = 5;
  localparam int CTRL_CTL_PHASE = 7;

  // Event register strobe bits (write one to fire).
  localparam int EVT_DOWNLOAD = 0;
  localparam int EVT_RESET_SP = 1;

  // ---------------------------------------------------------------
  // Reset values, lux (CTRL_RST is a control byte)
  // ---------------------------------------------------------------
  localparam logic [15:0] CFG_SP_RST    = 16'h0258;
  localparam logic [15:0] UPPER_LIM_RST = 16'h07D0;
  localparam logic [15:0] LOWER_LIM_RST = 16'h000A;
  localparam logic [7:0]  CTRL_RST      = 8'h01;

  // Four-bit relative dim: bit 3 direction, bits 2:0 step, step 0 = stop.
  localparam logic [2:0] DIM_STOP_STEP = 3'h0;

  typedef enum logic [1:0] {
    LSM_POL_ONE_ACTIVE,
    LSM_POL_ZERO_ACTIVE,
    LSM_POL_BOTH_ACTIVE
  } lsm_pol_e;

  typedef enum logic [1:0] {
    LSM_SRC_CONFIG,
    LSM_SRC_EXTERNAL,
    LSM_SRC_SHIFT_TEMP
  } lsm_src_e;

  typedef struct packed {
    logic       valid;
    logic [3:0] code;
  } lsm_dim_s;

endpackage

`default_nettype wire

// ===== rtl/lsm_float16.sv
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------
// 2-byte float to integer lux conversion
// ---------------------------------------------------------------
// Value = 0.01 * mantissa * 2^exp; negative values saturate to zero.
module lsm_float16 (
  // Encoded value
  input  wire logic [15:0] float_i,
  // Integer lux, saturated
  output logic      [15:0] lux_o
);

  logic [3:0]  exp_w;
  logic [10:0] mant_w;
  logic [31:0] scaled;
  logic [31:0] quot;

  assign exp_w  = float_i[14:11];
  assign mant_w = float_i[10:0];

  always_comb begin
    scaled = {21'h000000, mant_w} << exp_w;
    quot   = scaled / 32'h00000064;
    if (float_i[15]) begin
      lux_o = 16'h0000;
    end else if (quot > 32'h0000FFFF) begin
      lux_o = 16'hFFFF;
    end else begin
      lux_o = quot[15:0];
    end
  end

endmodule

`default_nettype wire

// ===== rtl/lsm_top.sv
//Contract
// - Without overwrite-on-download and with no preset or teach yet, the configured setpoint stays in use.
// - With the preset object enabled, a received 2-byte float lux value replaces the setpoint.
// - A preset setpoint holds until the next preset, shift, teach or setpoint-reset command.
// - A setpoint received over the bus survives a bus voltage failure.
// - With overwrite-on-download selected, a download restores the configured setpoint.
// - With shifting allowed, 4-bit dim telegrams during the control phase start a shift.
// - A stop telegram on the shift object is forwarded to channel 1.
// - Brightness above the upper limit stops the shift, sends stop and adopts the limit.
// - Brightness under the lower limit stops the shift, sends stop and adopts the limit.
// - A validity setting chooses a shift lasting to phase end or permanently.
// - A permanent shift holds until new preset, shift, teach or reset and survives bus failure.
// - With teach enabled, an active teach value captures measured brightness as setpoint.
// - Teach polarity is one-active, zero-active or both-active.
// - In a single-active polarity the opposite value restores the configured setpoint.
// - With both values active, teach never reverts to the configured setpoint.
`timescale 1ns/100ps
`default_nettype none

module lsm_top (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [7:0]  haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Channel 1 relative dimming output
  output logic             dim_valid_o,
  output logic      [3:0]  dim_code_o,
  // Effective setpoint, lux
  output logic      [15:0] setpoint_o
);

  // ---------------------------------------------------------------
  // Bus address phase capture
  // ---------------------------------------------------------------
  logic        wr_pend;
  logic        rd_pend;
  logic [7:0]  addr_q;
  logic        acc_w;

  // A transfer is taken only when the bus is ready and the slot holds a real request.
  assign acc_w = hsel_i && hready_i && htrans_i[1];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q  <= 8'h00;
    end else begin
      wr_pend <= acc_w && hwrite_i;
      rd_pend <= acc_w && !hwrite_i;
      if (acc_w) begin
        addr_q <= haddr_i;
      end
    end
  end

  // Zero wait states; every access answers OKAY.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [7:0]  ctrl;
  logic [15:0] cfg_sp;
  logic [15:0] upper_lim;
  logic [15:0] lower_lim;
  logic [15:0] meas;

  // Writes land at the end of the data phase, when hwdata_i is valid.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl      <= lsm_pkg::CTRL_RST;
      cfg_sp    <= lsm_pkg::CFG_SP_RST;
      upper_lim <= lsm_pkg::UPPER_LIM_RST;
      lower_lim <= lsm_pkg::LOWER_LIM_RST;
      meas      <= 16'h0000;
    end else if (wr_pend) begin
      unique case (addr_q)
        lsm_pkg::ADDR_CTRL: begin
          ctrl <= hwdata_i[7:0];
        end
        lsm_pkg::ADDR_CFG_SP: begin
          cfg_sp <= hwdata_i[15:0];
        end
        lsm_pkg::ADDR_LIMITS: begin
          lower_lim <= hwdata_i[15:0];
          upper_lim <= hwdata_i[31:16];
        end
        lsm_pkg::ADDR_MEAS: begin
          meas <= hwdata_i[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  logic       overwrite;
  logic       preset_en;
  logic       shift_en;
  logic       permanent;
  logic       teach_en;
  logic       ctl_phase;
  logic [1:0] pol;

  assign overwrite = ctrl[lsm_pkg::CTRL_OVERWRITE];
  assign preset_en = ctrl[lsm_pkg::CTRL_PRESET_EN];
  assign shift_en  = ctrl[lsm_pkg::CTRL_SHIFT_EN];
  assign permanent = ctrl[lsm_pkg::CTRL_PERMANENT];
  assign teach_en  = ctrl[lsm_pkg::CTRL_TEACH_EN];
  assign ctl_phase = ctrl[lsm_pkg::CTRL_CTL_PHASE];
  assign pol       = ctrl[lsm_pkg::CTRL_POL_LSB +: 2];

  // ---------------------------------------------------------------
  // Incoming telegram strobes
  // ---------------------------------------------------------------
  logic        wr_preset;
  logic        wr_shift;
  logic        wr_teach;
  logic        wr_event;
  logic [15:0] preset_lux;
  logic        phase_end;
  logic        ctl_phase_q;

  assign wr_preset = wr_pend && (addr_q == lsm_pkg::ADDR_PRESET);
  assign wr_shift  = wr_pend && (addr_q == lsm_pkg::ADDR_SHIFT);
  assign wr_teach  = wr_pend && (addr_q == lsm_pkg::ADDR_TEACH);
  assign wr_event  = wr_pend && (addr_q == lsm_pkg::ADDR_EVENT);
  assign phase_end = ctl_phase_q && !ctl_phase;

  // The converter works straight off the data phase; only wr_preset uses its result.
  lsm_float16 u_conv (
    .float_i (hwdata_i[15:0]),
    .lux_o   (preset_lux)
  );

  // The previous control-phase bit marks the phase end for temporary shifts.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctl_phase_q <= 1'b0;
    end else begin
      ctl_phase_q <= ctl_phase;
    end
  end

  // ---------------------------------------------------------------
  // Teach decoding
  // ---------------------------------------------------------------
  logic teach_active;
  logic teach_revert;

  always_comb begin
    teach_active = 1'b0;
    teach_revert = 1'b0;
    unique case (pol)
      2'h0: begin
        teach_active = hwdata_i[0];
        teach_revert = !hwdata_i[0];
      end
      2'h1: begin
        teach_active = !hwdata_i[0];
        teach_revert = hwdata_i[0];
      end
      // Codes 2 and 3 both select the both-active polarity.
      // both values capture
      default: begin
        teach_active = 1'b1;
        teach_revert = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Shift tracking
  // ---------------------------------------------------------------
  logic shifting;
  logic shift_go;
  logic shift_stop;
  logic over_hi;
  logic under_lo;

  assign shift_go   = wr_shift && shift_en && ctl_phase;
  assign shift_stop = shift_go && (hwdata_i[2:0] == lsm_pkg::DIM_STOP_STEP);
  assign over_hi    = shifting && (meas > upper_lim);
  assign under_lo   = shifting && (meas < lower_lim);

  // Limits are watched only while a shift runs, so a preset outside them stays in force.
  // Leaving the control phase ends any shift in progress.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      shifting <= 1'b0;
    end else if (over_hi || under_lo || shift_stop || !ctl_phase) begin
      shifting <= 1'b0;
    end else if (shift_go) begin
      shifting <= 1'b1;
    end
  end

  // A limit stop wins over a telegram in the same cycle, so the lighting never runs past a limit.
  // channel 1 dim output
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dim_valid_o <= 1'b0;
      dim_code_o  <= 4'h0;
    end else if (over_hi || under_lo) begin
      dim_valid_o <= 1'b1;
      dim_code_o  <= {1'b0, lsm_pkg::DIM_STOP_STEP};
    end else if (shift_go) begin
      dim_valid_o <= 1'b1;
      dim_code_o  <= hwdata_i[3:0];
    end else begin
      dim_valid_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Setpoint selection
  // ---------------------------------------------------------------
  // The held setpoint lives in retained storage: no bus-failure input
  // exists, so only an overwriting download, an explicit reset, a reverting teach value or the phase end after a temporary shift returns it.
  logic [15:0] held_sp;
  logic [15:0] saved_sp;
  logic [1:0]  src;
  logic        shift_take;

  assign shift_take = over_hi || under_lo || (shift_stop && shifting);

  // Events outrank telegrams, and a limit stop outranks a stop telegram.
  // config value until override
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      held_sp  <= lsm_pkg::CFG_SP_RST;
      src      <= lsm_pkg::LSM_SRC_CONFIG;
    end else if (wr_event && hwdata_i[lsm_pkg::EVT_RESET_SP]) begin
      src <= lsm_pkg::LSM_SRC_CONFIG;
    end else if (wr_event && hwdata_i[lsm_pkg::EVT_DOWNLOAD] && overwrite) begin
      src <= lsm_pkg::LSM_SRC_CONFIG;
    end else if (over_hi) begin
      held_sp <= upper_lim;
      src     <= permanent ? lsm_pkg::LSM_SRC_EXTERNAL : lsm_pkg::LSM_SRC_SHIFT_TEMP;
    end else if (under_lo) begin
      held_sp <= lower_lim;
      src     <= permanent ? lsm_pkg::LSM_SRC_EXTERNAL : lsm_pkg::LSM_SRC_SHIFT_TEMP;
    end else if (shift_stop && shifting) begin
      held_sp <= meas;
      src     <= permanent ? lsm_pkg::LSM_SRC_EXTERNAL : lsm_pkg::LSM_SRC_SHIFT_TEMP;
    end else if (wr_preset && preset_en) begin
      held_sp <= preset_lux;
      src     <= lsm_pkg::LSM_SRC_EXTERNAL;
    end else if (wr_teach && teach_en && teach_active) begin
      held_sp <= meas;
      src     <= lsm_pkg::LSM_SRC_EXTERNAL;
    end else if (wr_teach && teach_en && teach_revert) begin
      src <= lsm_pkg::LSM_SRC_CONFIG;
    end else if (phase_end && src == lsm_pkg::LSM_SRC_SHIFT_TEMP) begin
      held_sp <= saved_sp;
      src     <= (saved_sp == cfg_sp) ? lsm_pkg::LSM_SRC_CONFIG : lsm_pkg::LSM_SRC_EXTERNAL;
    end
  end

  // Keep the setpoint in force before the first temporary shift of a phase,
  // whichever way that shift ends, so the phase end can put it back.
  // phase-end restore point
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      saved_sp <= lsm_pkg::CFG_SP_RST;
    end else if (shift_take && src != lsm_pkg::LSM_SRC_SHIFT_TEMP) begin
      saved_sp <= setpoint_o;
    end
  end

  // ---------------------------------------------------------------
  // Effective setpoint output
  // ---------------------------------------------------------------
  // The output follows the configured value live while no override holds.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      setpoint_o <= lsm_pkg::CFG_SP_RST;
    end else if (src == lsm_pkg::LSM_SRC_CONFIG) begin
      setpoint_o <= cfg_sp;
    end else begin
      setpoint_o <= held_sp;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Read data is registered in the address phase, so it stands for the whole data phase.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h00000000;
    end else if (acc_w && !hwrite_i) begin
      unique case (haddr_i)
        lsm_pkg::ADDR_CTRL:     hrdata_o <= {24'h000000, ctrl};
        lsm_pkg::ADDR_CFG_SP:   hrdata_o <= {16'h0000, cfg_sp};
        lsm_pkg::ADDR_LIMITS:   hrdata_o <= {upper_lim, lower_lim};
        lsm_pkg::ADDR_MEAS:     hrdata_o <= {16'h0000, meas};
        lsm_pkg::ADDR_SETPOINT: hrdata_o <= {16'h0000, setpoint_o};
        lsm_pkg::ADDR_STATUS:   hrdata_o <= {29'h00000000, shifting, src};
        lsm_pkg::ADDR_DIM_OUT:  hrdata_o <= {27'h0000000, dim_valid_o, dim_code_o};
        default:                hrdata_o <= 32'h00000000;
      endcase
    end
  end

endmodule

`default_nettype wire

// ===== bench/lsm_props.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// Setpoint manager checker
// ---------------------------------------------------------------
module lsm_props (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // Bus
  input wire logic        hsel_i,
  input wire logic [7:0]  haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  // Outputs
  input wire logic        dim_valid_o,
  input wire logic [3:0]  dim_code_o,
  input wire logic [15:0] setpoint_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic        aph;
  logic        aw_sh;
  logic        sh_ok;
  logic        wp;
  logic [7:0]  wa;
  logic        dw_ev;
  logic        dw_te;
  logic        act;
  logic [31:0] ctl;
  logic [31:0] lim;
  logic [15:0] cfg;
  logic [15:0] meas;
  assign aph = hsel_i && hready_i && htrans_i[1];
  assign aw_sh = aph && hwrite_i && haddr_i == lsm_pkg::ADDR_SHIFT;
  assign sh_ok = ctl[lsm_pkg::CTRL_SHIFT_EN] && ctl[lsm_pkg::CTRL_CTL_PHASE];
  assign dw_ev = wp && wa == lsm_pkg::ADDR_EVENT;
  assign dw_te = wp && wa == lsm_pkg::ADDR_TEACH && ctl[lsm_pkg::CTRL_TEACH_EN];
  assign act = ctl[6] | (hwdata_i[0] ^ ctl[5]);
  // Shadow copies, so the properties can name the figures software set.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wp <= 1'b0;
      wa <= 8'h00;
      ctl <= {24'h0, lsm_pkg::CTRL_RST};
      lim <= {lsm_pkg::UPPER_LIM_RST, lsm_pkg::LOWER_LIM_RST};
      cfg <= lsm_pkg::CFG_SP_RST;
      meas <= 16'h0000;
    end else begin
      wp <= aph && hwrite_i;
      wa <= haddr_i;
      if (wp && wa == lsm_pkg::ADDR_CTRL) ctl <= hwdata_i;
      if (wp && wa == lsm_pkg::ADDR_LIMITS) lim <= hwdata_i;
      if (wp && wa == lsm_pkg::ADDR_CFG_SP) cfg <= hwdata_i[15:0];
      if (wp && wa == lsm_pkg::ADDR_MEAS) meas <= hwdata_i[15:0];
    end
  end
  shift_fwd_a: assert property (aw_sh && sh_ok |-> ##2 (dim_valid_o && dim_code_o == $past(hwdata_i[3:0])))
    else $error("Shift telegram not forwarded.");
  shift_drop_a: assert property (aw_sh && !sh_ok |-> ##2 !dim_valid_o)
    else $error("Refused shift telegram forwarded.");
  dim_cause_a: assert property (dim_valid_o && dim_code_o[2:0] != 3'h0 |-> $past(aw_sh, 2))
    else $error("Dim step without a shift telegram.");
  limit_adopt_a: assert property (dim_valid_o && !$past(aw_sh, 2) |->
    dim_code_o == 4'h0 ##[1:3] (setpoint_o == lim[15:0] || setpoint_o == lim[31:16]))
    else $error("Limit stop did not adopt a limit.");
  download_cfg_a: assert property (dw_ev && hwdata_i[0] && ctl[0] |-> ##[1:3] setpoint_o == cfg)
    else $error("Download kept a foreign setpoint.");
  reset_cfg_a: assert property (dw_ev && hwdata_i[1] |-> ##[1:3] setpoint_o == cfg)
    else $error("Setpoint reset ignored.");
  teach_cap_a: assert property (dw_te && act |-> ##[1:3] setpoint_o == meas)
    else $error("Teach did not capture brightness.");
  teach_back_a: assert property (dw_te && !act |-> ##[1:3] setpoint_o == cfg)
    else $error("Inactive teach did not restore.");
  cover property (aw_sh && sh_ok);
  cover property (dim_valid_o && !$past(aw_sh, 2));
  cover property (dw_te && act);
endmodule
bind lsm_top lsm_props lsm_props_inst (.clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i,
  .hready_i, .dim_valid_o, .dim_code_o, .setpoint_o);
`default_nettype wire

// ===== bench/lsm_dim_model.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// Channel 1 dimming actuator
// ---------------------------------------------------------------
module lsm_dim_model (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // Telegrams
  input  wire lsm_pkg::lsm_dim_s dim_i,
  // Actuator state
  output logic [3:0]             last_code_o,
  output logic [7:0]             pulse_cnt_o,
  output logic                   dimming_o
);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      last_code_o <= 4'h0;
      pulse_cnt_o <= 8'h00;
      dimming_o <= 1'b0;
    end else if (dim_i.valid) begin
      last_code_o <= dim_i.code;
      pulse_cnt_o <= pulse_cnt_o + 8'h01;
      dimming_o <= dim_i.code[2:0] != lsm_pkg::DIM_STOP_STEP;
    end
  end
endmodule
`default_nettype wire

// ===== bench/lsm_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module lsm_tb_top;
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                hsel = 1'b0;
  logic [7:0]          haddr = 8'h00;
  logic [1:0]          htrans = 2'h0;
  logic                hwrite = 1'b0;
  logic [2:0]          hsize = 3'h0;
  logic                resp;
  logic                dmg;
  logic [31:0]         hwdata = 32'h0;
  logic [31:0]         hrdata;
  logic                rdy;
  logic                dv;
  logic [3:0]          dc;
  logic [15:0]         sp;
  lsm_pkg::lsm_dim_s   dim;
  logic [3:0]          last;
  logic [7:0]          cnt;
  logic [31:0]         seed = 32'h6A01;
  logic [10:0]         m;
  logic [3:0]          e;
  logic [15:0]         x;
  int                  error_cnt = 0;
  int                  total_checks = 0;
  always #12.5 clk = ~clk;
  assign dim = {dv, dc};
  lsm_top lsm_top_inst (.clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(rdy), .hrdata_o(hrdata), .hreadyout_o(rdy),
    .hresp_o(resp), .dim_valid_o(dv), .dim_code_o(dc), .setpoint_o(sp));
  lsm_dim_model lsm_dim_model_inst (.clk_i(clk), .rst_n_i(rst_n), .dim_i(dim), .last_code_o(last),
    .pulse_cnt_o(cnt), .dimming_o(dmg));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Exact only for values the callers pick, so no rounding is assumed.
  function automatic logic [15:0] flux(input logic [10:0] mm, input logic [3:0] ee);
    logic [31:0] v;
    v = ({21'h0, mm} << ee) / 32'h64;
    return v[15:0];
  endfunction
  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 64);
    if (rdy !== 1'b1) begin
      error_cnt++;
      final_report();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    seed = lfsr(seed);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : seed;
    wait_rdy();
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(r, exp);
  endtask
  task automatic sp_is(input logic [15:0] exp);
    repeat (4) @(posedge clk);
    check({16'h0, sp}, {16'h0, exp});
  endtask
  task automatic dim_is(input logic [3:0] code, input logic [7:0] n);
    repeat (4) @(posedge clk);
    check({20'h0, last, cnt}, {20'h0, code, n});
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check({16'h0, sp}, {16'h0, lsm_pkg::CFG_SP_RST});
    rd(lsm_pkg::ADDR_CTRL, {24'h0, lsm_pkg::CTRL_RST});
    rd(lsm_pkg::ADDR_LIMITS, {lsm_pkg::UPPER_LIM_RST, lsm_pkg::LOWER_LIM_RST});
    rd(8'h2C, 32'h0);
    check({31'h0, resp}, 32'h0);
    wr(lsm_pkg::ADDR_CTRL, 32'h80);
    wr(lsm_pkg::ADDR_CFG_SP, 32'h1F4);
    sp_is(16'h1F4);
    wr(lsm_pkg::ADDR_PRESET, 32'h23E8);
    wr(lsm_pkg::ADDR_SHIFT, 32'hB);
    wr(lsm_pkg::ADDR_TEACH, 32'h1);
    sp_is(16'h1F4);
    dim_is(4'h0, 8'h0);
    wr(lsm_pkg::ADDR_CTRL, 32'h2);
    wr(lsm_pkg::ADDR_PRESET, 32'h87D0);
    sp_is(16'h0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      m = (11'(seed[5:0]) + 11'h1) * 11'h19;
      e = 4'h2 + 4'(seed[7:6]);
      x = flux(m, e);
      wr(lsm_pkg::ADDR_PRESET, {16'h0, 1'b0, e, m});
      sp_is(x);
      rd(lsm_pkg::ADDR_SETPOINT, {16'h0, x});
    end
    wr(lsm_pkg::ADDR_EVENT, 32'h1);
    sp_is(x);
    wr(lsm_pkg::ADDR_CTRL, 32'h3);
    wr(lsm_pkg::ADDR_EVENT, 32'h1);
    sp_is(16'h1F4);
    wr(lsm_pkg::ADDR_PRESET, 32'h07D0);
    sp_is(16'h14);
    wr(lsm_pkg::ADDR_EVENT, 32'h2);
    sp_is(16'h1F4);
    wr(lsm_pkg::ADDR_MEAS, 32'h190);
    wr(lsm_pkg::ADDR_LIMITS, 32'h0320_0064);
    wr(lsm_pkg::ADDR_CTRL, 32'h4);
    wr(lsm_pkg::ADDR_SHIFT, 32'h9);
    dim_is(4'h0, 8'h0);
    wr(lsm_pkg::ADDR_CTRL, 32'h84);
    wr(lsm_pkg::ADDR_SHIFT, 32'hB);
    dim_is(4'hB, 8'h1);
    check({31'h0, dmg}, 32'h1);
    wr(lsm_pkg::ADDR_MEAS, 32'h1C2);
    wr(lsm_pkg::ADDR_SHIFT, 32'h8);
    dim_is(4'h8, 8'h2);
    check({31'h0, dmg}, 32'h0);
    sp_is(16'h1C2);
    wr(lsm_pkg::ADDR_CTRL, 32'h4);
    sp_is(16'h1F4);
    // A temporary shift ended by a limit must still fall back to the earlier preset.
    wr(lsm_pkg::ADDR_CTRL, 32'h86);
    wr(lsm_pkg::ADDR_PRESET, 32'h07D0);
    wr(lsm_pkg::ADDR_SHIFT, 32'h3);
    wr(lsm_pkg::ADDR_MEAS, 32'h384);
    sp_is(16'h320);
    wr(lsm_pkg::ADDR_CTRL, 32'h6);
    sp_is(16'h14);
    wr(lsm_pkg::ADDR_MEAS, 32'h1C2);
    wr(lsm_pkg::ADDR_CTRL, 32'h8C);
    wr(lsm_pkg::ADDR_SHIFT, 32'h3);
    wr(lsm_pkg::ADDR_MEAS, 32'h384);
    dim_is(4'h0, 8'h6);
    sp_is(16'h320);
    wr(lsm_pkg::ADDR_MEAS, 32'h190);
    wr(lsm_pkg::ADDR_SHIFT, 32'hB);
    wr(lsm_pkg::ADDR_MEAS, 32'h32);
    dim_is(4'h0, 8'h8);
    sp_is(16'h64);
    wr(lsm_pkg::ADDR_MEAS, 32'h12C);
    wr(lsm_pkg::ADDR_SHIFT, 32'h1);
    wr(lsm_pkg::ADDR_SHIFT, 32'h0);
    wr(lsm_pkg::ADDR_CTRL, 32'hC);
    sp_is(16'h12C);
    for (int p = 0; p < 3; p++) begin
      seed = lfsr(seed);
      x = 16'h14 + 16'(seed[9:0]);
      wr(lsm_pkg::ADDR_CTRL, 32'h10 | (32'(p) << 5));
      wr(lsm_pkg::ADDR_MEAS, {16'h0, x});
      wr(lsm_pkg::ADDR_TEACH, {31'h0, p != 1});
      sp_is(x);
      wr(lsm_pkg::ADDR_TEACH, {31'h0, p == 1});
      sp_is(p == 2 ? x : 16'h1F4);
    end
    final_report();
  end
endmodule
`default_nettype wire
